// [src/amc_map.svh]
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef AMC_MAP_SVH
`define AMC_MAP_SVH

`define AMC_OFS_CTRL     8'hb8
`define AMC_OFS_REF      8'hb9
`define AMC_OFS_PAIR     8'hba
`define AMC_OFS_CHAN     8'hbb
`define AMC_OFS_RES_HI   8'hbc
`define AMC_OFS_RES_LO   8'hbd
`define AMC_OFS_WIN_HI   8'hbe
`define AMC_OFS_WIN_LO   8'hbf

`define AMC_CTRL_EN_BIT    0
`define AMC_CTRL_START_BIT 1
`define AMC_CTRL_DONE_BIT  2
`define AMC_CTRL_WIN_BIT   3
`define AMC_CTRL_GAIN_LSB  4
`define AMC_CTRL_GAIN_MSB  6
`define AMC_REF_BIAS_BIT   0

`define AMC_RST_EN       1'b0
`define AMC_RST_BIAS     1'b0
`define AMC_RST_GAIN     3'h0
`define AMC_RST_PAIR     4'h0
`define AMC_RST_CHAN     4'h0
`define AMC_RST_WIN_HI   8'hff
`define AMC_RST_WIN_LO   8'h00
`define AMC_RST_RESULT   10'h000
`define AMC_DAC_MID      10'h200

`define AMC_CLK_NS       10
`define AMC_MIN_CONV_NS  10000
`define AMC_TRACK_CLKS   3
`define AMC_RES_BITS     10
`define AMC_SAR_CLKS     (`AMC_TRACK_CLKS + `AMC_RES_BITS)
`define AMC_CONV_CYCLES  ((`AMC_MIN_CONV_NS + `AMC_CLK_NS - 1) / `AMC_CLK_NS)
`define AMC_BIT_CYCLES   ((`AMC_CONV_CYCLES + `AMC_SAR_CLKS - 1) / `AMC_SAR_CLKS)

`endif

// [src/amc_pkg.sv]
// types shared by the converter control files
package amc_pkg;

  typedef enum logic [1:0] {
    SAR_IDLE,
    SAR_TRACK,
    SAR_CONVERT
  } amc_sar_state_e;

  typedef struct packed {
    logic       tempSel;
    logic       diff;
    logic [2:0] posCh;
    logic [2:0] negCh;
  } amc_mux_sel_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } amc_bus_req_s;

  function automatic logic amc_hit(input logic [7:0] addr, input logic [7:0] ofs);
    amc_hit = (addr == ofs);
  endfunction

endpackage

// [src/amc_sel_decode.sv]
// decodes channel select code and pair configuration into a selector setting
`timescale 1ns/1ps

module amc_sel_decode (
  input  wire logic [3:0]           selCode,
  input  wire logic [3:0]           pairCfg,
  output amc_pkg::amc_mux_sel_s     muxSel
);

  logic [1:0] pairIdx;

  always_comb begin
    pairIdx = selCode[2:1];
    muxSel  = '0;
    if (selCode[3]) begin
      muxSel.tempSel = 1'b1;
    end else if (pairCfg[pairIdx]) begin
      // either member of a differential pair names the pair
      muxSel.diff  = 1'b1;
      muxSel.posCh = {pairIdx, 1'b0};
      muxSel.negCh = {pairIdx, 1'b1};
    end else begin
      muxSel.posCh = selCode[2:0];
    end
  end

endmodule

// [src/amc_top.sv]
// control of the successive-approximation converter and its nine-channel input selector
//
// Behaviour
// - converter, hold stage, amplifier powered only when enabled
// - disabled means shutdown and no conversions
// - nine channels, eight external inputs
// - ninth channel is the temperature sensor
// - each pair single-ended or differential, live
// - reset makes every pair single-ended
// - ten-bit successive approximation, window detector, 100ksps
// - everything set through software registers
// - pair bits 0..3, lower input positive
// - codes 0..7 external, top bit temperature
// - differential results are two's complement
`timescale 1ns/1ps
`include "amc_map.svh"

module amc_top #(
  parameter int BIT_CYCLES = `AMC_BIT_CYCLES,
  parameter int RES_BITS   = `AMC_RES_BITS
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [7:0]            regAddr,
  input  wire logic [7:0]            regWdata,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic      [7:0]            regRdata,
  input  wire logic                  compIn,
  output logic                       converterPower,
  output logic                       trackHoldPower,
  output logic                       gainAmpPower,
  output logic                       biasOn,
  output logic                       trackOn,
  output logic                       convBusy,
  output logic      [RES_BITS-1:0]   dacCode,
  output logic      [2:0]            gainSel,
  output amc_pkg::amc_mux_sel_s      muxSel
);

  localparam int CNT_W = $clog2(BIT_CYCLES * `AMC_TRACK_CLKS + 1);
  localparam logic [CNT_W-1:0] BIT_LAST   = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] TRACK_LAST = CNT_W'(BIT_CYCLES * `AMC_TRACK_CLKS - 1);

  amc_pkg::amc_bus_req_s req;

  // software-visible state
  logic                   enable_reg,  enable_next;
  logic                   bias_reg,    bias_next;
  logic [2:0]             gain_reg,    gain_next;
  logic [3:0]             pair_reg,    pair_next;
  logic [3:0]             chan_reg,    chan_next;
  logic [7:0]             winHi_reg,   winHi_next;
  logic [7:0]             winLo_reg,   winLo_next;
  logic                   done_reg,    done_next;
  logic                   winFlag_reg, winFlag_next;
  logic [RES_BITS-1:0]    result_reg,  result_next;
  logic                   resDiff_reg, resDiff_next;
  logic [7:0]             rdata_reg,   rdata_next;

  // sequencer state
  amc_pkg::amc_sar_state_e state_reg, state_next;
  logic [CNT_W-1:0]        cnt_reg,   cnt_next;
  logic [3:0]              bitIdx_reg, bitIdx_next;
  logic [RES_BITS-1:0]     dac_reg,   dac_next;
  logic                    convDiff_reg, convDiff_next;
  amc_pkg::amc_mux_sel_s   sel_reg,   sel_next;

  logic                    startReq;
  logic                    convDone;
  logic [RES_BITS-1:0]     finalCode;
  logic [RES_BITS-1:0]     formatted;
  logic                    winHit;
  amc_pkg::amc_mux_sel_s   selDecoded;
  logic                    ctrlWr;
  logic                    enNow;
  logic                    biasNow;
  logic                    powerOk;

  assign req.addr  = regAddr;
  assign req.wdata = regWdata;
  assign req.wr    = regWr;
  assign req.rd    = regRd;

  amc_sel_decode u_decode (
    .selCode (chan_reg),
    .pairCfg (pair_reg),
    .muxSel  (selDecoded)
  );

  // register writes and sticky flags
  always_comb begin
    enable_next  = enable_reg;
    bias_next    = bias_reg;
    gain_next    = gain_reg;
    pair_next    = pair_reg;
    chan_next    = chan_reg;
    winHi_next   = winHi_reg;
    winLo_next   = winLo_reg;
    done_next    = done_reg;
    winFlag_next = winFlag_reg;
    result_next  = result_reg;
    resDiff_next = resDiff_reg;
    ctrlWr       = req.wr && amc_pkg::amc_hit(req.addr, `AMC_OFS_CTRL);
    if (ctrlWr) begin
      enable_next = req.wdata[`AMC_CTRL_EN_BIT];
      gain_next   = req.wdata[`AMC_CTRL_GAIN_MSB:`AMC_CTRL_GAIN_LSB];
      // write one clears a flag
      if (req.wdata[`AMC_CTRL_DONE_BIT]) begin
        done_next = 1'b0;
      end
      if (req.wdata[`AMC_CTRL_WIN_BIT]) begin
        winFlag_next = 1'b0;
      end
    end
    if (req.wr && amc_pkg::amc_hit(req.addr, `AMC_OFS_REF)) begin
      bias_next = req.wdata[`AMC_REF_BIAS_BIT];
    end
    if (req.wr && amc_pkg::amc_hit(req.addr, `AMC_OFS_PAIR)) begin
      pair_next = req.wdata[3:0];
    end
    if (req.wr && amc_pkg::amc_hit(req.addr, `AMC_OFS_CHAN)) begin
      chan_next = req.wdata[3:0];
    end
    if (req.wr && amc_pkg::amc_hit(req.addr, `AMC_OFS_WIN_HI)) begin
      winHi_next = req.wdata;
    end
    if (req.wr && amc_pkg::amc_hit(req.addr, `AMC_OFS_WIN_LO)) begin
      winLo_next = req.wdata;
    end
    // completion comes after the clear so a coincident event is kept
    if (convDone) begin
      result_next  = formatted;
      resDiff_next = convDiff_reg;
      done_next    = 1'b1;
      if (winHit) begin
        winFlag_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_reg  <= `AMC_RST_EN;
      bias_reg    <= `AMC_RST_BIAS;
      gain_reg    <= `AMC_RST_GAIN;
      pair_reg    <= `AMC_RST_PAIR;
      chan_reg    <= `AMC_RST_CHAN;
      winHi_reg   <= `AMC_RST_WIN_HI;
      winLo_reg   <= `AMC_RST_WIN_LO;
      done_reg    <= 1'b0;
      winFlag_reg <= 1'b0;
      result_reg  <= `AMC_RST_RESULT;
      resDiff_reg <= 1'b0;
    end else begin
      enable_reg  <= enable_next;
      bias_reg    <= bias_next;
      gain_reg    <= gain_next;
      pair_reg    <= pair_next;
      chan_reg    <= chan_next;
      winHi_reg   <= winHi_next;
      winLo_reg   <= winLo_next;
      done_reg    <= done_next;
      winFlag_reg <= winFlag_next;
      result_reg  <= result_next;
      resDiff_reg <= resDiff_next;
    end
  end

  // start needs the enable of this very write and a biased converter
  assign startReq = ctrlWr && req.wdata[`AMC_CTRL_START_BIT] && req.wdata[`AMC_CTRL_EN_BIT]
                    && bias_reg && (state_reg == amc_pkg::SAR_IDLE);

  // enable and bias as they stand after this edge: a clearing write stops at once,
  // and a start that sets the enable in the same write is not taken for an abort
  assign enNow   = (req.wr && amc_pkg::amc_hit(req.addr, `AMC_OFS_CTRL))
                   ? req.wdata[`AMC_CTRL_EN_BIT] : enable_reg;
  assign biasNow = (req.wr && amc_pkg::amc_hit(req.addr, `AMC_OFS_REF))
                   ? req.wdata[`AMC_REF_BIAS_BIT] : bias_reg;
  assign powerOk = enNow && biasNow;

  // final bit decision folded in combinationally so the result lands with done
  always_comb begin
    finalCode = dac_reg;
    if (!compIn) begin
      finalCode[0] = 1'b0;
    end
  end

  // offset binary from the array becomes two's complement by flipping the top bit
  assign formatted = convDiff_reg ? {~finalCode[RES_BITS-1], finalCode[RES_BITS-2:0]}
                                  : finalCode;
  // window compares the upper eight bits as unsigned codes
  assign winHit = (formatted[RES_BITS-1 -: 8] >= winLo_reg)
                  && (formatted[RES_BITS-1 -: 8] <= winHi_reg);
  assign convDone = (state_reg == amc_pkg::SAR_CONVERT) && powerOk
                    && (cnt_reg == BIT_LAST) && (bitIdx_reg == 4'h0);

  // successive-approximation sequencer
  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    bitIdx_next   = bitIdx_reg;
    dac_next      = dac_reg;
    convDiff_next = convDiff_reg;
    sel_next      = selDecoded;
    case (state_reg)
      amc_pkg::SAR_IDLE: begin
        cnt_next = '0;
        if (startReq) begin
          convDiff_next = selDecoded.diff;
          state_next    = amc_pkg::SAR_TRACK;
        end
      end
      amc_pkg::SAR_TRACK: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == TRACK_LAST) begin
          cnt_next    = '0;
          bitIdx_next = 4'(RES_BITS - 1);
          dac_next    = `AMC_DAC_MID;
          state_next  = amc_pkg::SAR_CONVERT;
        end
      end
      amc_pkg::SAR_CONVERT: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == BIT_LAST) begin
          cnt_next = '0;
          if (!compIn) begin
            dac_next[bitIdx_reg] = 1'b0;
          end
          if (bitIdx_reg == 4'h0) begin
            state_next = amc_pkg::SAR_IDLE;
          end else begin
            bitIdx_next             = bitIdx_reg - 1'b1;
            dac_next[bitIdx_reg - 1'b1] = 1'b1;
          end
        end
      end
      default: begin
        state_next = amc_pkg::SAR_IDLE;
      end
    endcase
    // losing enable or bias aborts at once; no partial result is stored
    if (!powerOk) begin
      state_next = amc_pkg::SAR_IDLE;
      cnt_next   = '0;
      dac_next   = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg    <= amc_pkg::SAR_IDLE;
      cnt_reg      <= '0;
      bitIdx_reg   <= 4'h0;
      dac_reg      <= '0;
      convDiff_reg <= 1'b0;
      sel_reg      <= '0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      bitIdx_reg   <= bitIdx_next;
      dac_reg      <= dac_next;
      convDiff_reg <= convDiff_next;
      sel_reg      <= sel_next;
    end
  end

  // read port, data one cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    if (req.rd) begin
      case (req.addr)
        `AMC_OFS_CTRL: begin
          rdata_next[`AMC_CTRL_EN_BIT]                        = enable_reg;
          rdata_next[`AMC_CTRL_START_BIT]                     = convBusy;
          rdata_next[`AMC_CTRL_DONE_BIT]                      = done_reg;
          rdata_next[`AMC_CTRL_WIN_BIT]                       = winFlag_reg;
          rdata_next[`AMC_CTRL_GAIN_MSB:`AMC_CTRL_GAIN_LSB]   = gain_reg;
        end
        `AMC_OFS_REF: begin
          rdata_next[`AMC_REF_BIAS_BIT] = bias_reg;
        end
        `AMC_OFS_PAIR: begin
          rdata_next = {4'h0, pair_reg};
        end
        `AMC_OFS_CHAN: begin
          rdata_next = {4'h0, chan_reg};
        end
        `AMC_OFS_RES_HI: begin
          rdata_next = {{6{result_reg[RES_BITS-1] & resDiff_reg}},
                        result_reg[RES_BITS-1 -: 2]};
        end
        `AMC_OFS_RES_LO: begin
          rdata_next = result_reg[7:0];
        end
        `AMC_OFS_WIN_HI: begin
          rdata_next = winHi_reg;
        end
        `AMC_OFS_WIN_LO: begin
          rdata_next = winLo_reg;
        end
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign regRdata       = rdata_reg;
  assign converterPower = enable_reg;
  assign trackHoldPower = enable_reg;
  assign gainAmpPower   = enable_reg;
  assign biasOn         = bias_reg;
  assign trackOn        = (state_reg == amc_pkg::SAR_TRACK);
  assign convBusy       = (state_reg != amc_pkg::SAR_IDLE);
  assign dacCode        = dac_reg;
  assign gainSel        = gain_reg;
  assign muxSel         = sel_reg;

endmodule

// [verification/amc_top_props.sv]
// checker on the converter control ports
`timescale 1ns/1ps
`include "amc_map.svh"
module amc_top_props #(
  parameter int BIT_CYCLES = `AMC_BIT_CYCLES
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic [7:0]            regAddr,
  input wire logic [7:0]            regWdata,
  input wire logic                  regWr,
  input wire logic                  regRd,
  input wire logic [7:0]            regRdata,
  input wire logic                  converterPower,
  input wire logic                  trackHoldPower,
  input wire logic                  gainAmpPower,
  input wire logic                  biasOn,
  input wire logic                  trackOn,
  input wire logic                  convBusy,
  input wire logic [9:0]            dacCode,
  input wire amc_pkg::amc_mux_sel_s muxSel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // wide enough for the full conversion length at the default bit period
  logic [15:0] trkCnt_reg, trkCnt_next, busyCnt_reg, busyCnt_next;
  always_comb begin
    trkCnt_next = trackOn ? trkCnt_reg + 16'h0001 : 16'h0000;
    busyCnt_next = convBusy ? busyCnt_reg + 16'h0001 : 16'h0000;
  end
  // counters restart on reset so a mid-run reset cannot leave a stale length
  always_ff @(posedge clk) begin
    trkCnt_reg <= rst_n ? trkCnt_next : 16'h0000;
    busyCnt_reg <= rst_n ? busyCnt_next : 16'h0000;
  end
  AST_PWR_SAME: assert property (
    trackHoldPower == converterPower && gainAmpPower == converterPower)
    else $error("power outputs differ");
  AST_PWR_WR: assert property (
    regWr && regAddr == `AMC_OFS_CTRL |=> converterPower == $past(regWdata[0]))
    else $error("power does not follow enable");
  AST_OFF_IDLE: assert property (!converterPower |-> !convBusy)
    else $error("busy while disabled");
  AST_NO_BIAS: assert property (!biasOn |-> !convBusy)
    else $error("busy without bias");
  AST_START: assert property (regWr && regAddr == `AMC_OFS_CTRL && regWdata[1:0] == 2'b11
    && biasOn && !convBusy |=> convBusy && trackOn)
    else $error("start not taken");
  AST_TRK_LEN: assert property ($fell(trackOn) && convBusy |-> trkCnt_reg == 3 * BIT_CYCLES)
    else $error("track length wrong");
  AST_DAC_MID: assert property ($fell(trackOn) && convBusy |-> dacCode == `AMC_DAC_MID)
    else $error("first trial code wrong");
  AST_CONV_LEN: assert property ($fell(convBusy) && converterPower && biasOn
    |-> busyCnt_reg == 13 * BIT_CYCLES)
    else $error("conversion length wrong");
  AST_RD_IDLE: assert property (!regRd |=> regRdata == 8'h00)
    else $error("read data outside read slot");
  AST_RD_UPPER: assert property (
    regRd && (regAddr == `AMC_OFS_PAIR || regAddr == `AMC_OFS_CHAN) |=> regRdata[7:4] == 4'h0)
    else $error("unused bits not zero");
  AST_TEMP: assert property (regWr && regAddr == `AMC_OFS_CHAN
    |-> ##2 muxSel.tempSel == $past(regWdata[3], 2))
    else $error("temperature select wrong");
  AST_SE_NEG: assert property (!muxSel.diff |-> muxSel.negCh == 3'h0)
    else $error("negative input set single ended");
  AST_DIFF: assert property (
    muxSel.diff |-> !muxSel.posCh[0] && muxSel.negCh == muxSel.posCh + 3'h1)
    else $error("pair members wrong");
  cover property ($fell(convBusy) && converterPower);
  cover property ($fell(convBusy) && !converterPower);
  cover property (muxSel.diff);
  cover property (muxSel.tempSel);
endmodule
bind amc_top amc_top_props #(.BIT_CYCLES(BIT_CYCLES)) u_props (.clk, .rst_n, .regAddr, .regWdata,
  .regWr, .regRd, .regRdata, .converterPower, .trackHoldPower, .gainAmpPower, .biasOn,
  .trackOn, .convBusy, .dacCode, .muxSel);

// [verification/amc_analog_model.sv]
// analog levels and comparator on the selector's far side
`timescale 1ns/1ps
module amc_analog_model (
  input  wire logic                  clk,
  input  wire logic                  trackOn,
  input  wire amc_pkg::amc_mux_sel_s muxSel,
  input  wire logic [9:0]            dacCode,
  output logic                       compIn
);
  logic [9:0] held;
  function automatic logic [9:0] lvl(input logic [2:0] ch);
    lvl = 10'(ch) * 10'h05b + 10'h0a7;
  endfunction
  initial held = 10'h155;
  // hold stage keeps the last tracked level through the whole conversion
  always @(posedge clk) begin
    if (trackOn) begin
      if (muxSel.tempSel) held <= 10'h2c9;
      else if (muxSel.diff) held <= lvl(muxSel.posCh) - lvl(muxSel.negCh) + 10'h200;
      else held <= lvl(muxSel.posCh);
    end
  end
  assign compIn = held >= dacCode;
endmodule

// [verification/amc_top_tb.sv]
// scenarios for the converter control and its input selector
`timescale 1ns/1ps
`include "amc_map.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module amc_top_tb;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [7:0]            regAddr = 8'h00;
  logic [7:0]            regWdata = 8'h00;
  logic                  regWr = 1'b0;
  logic                  regRd = 1'b0;
  logic [7:0]            regRdata;
  logic                  compIn, converterPower, trackHoldPower, gainAmpPower;
  logic                  biasOn, trackOn, convBusy;
  logic [9:0]            dacCode;
  logic [2:0]            gainSel;
  amc_pkg::amc_mux_sel_s muxSel, expSel;
  int                    n_fail = 0;
  int                    check_count = 0;
  always #5 clk = ~clk;
  // short bit period keeps each conversion at 26 cycles
  amc_top #(.BIT_CYCLES(2)) u_dut (.clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .compIn, .converterPower, .trackHoldPower, .gainAmpPower, .biasOn, .trackOn, .convBusy,
    .dacCode, .gainSel, .muxSel);
  amc_analog_model u_far (.clk, .trackOn, .muxSel, .dacCode, .compIn);
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_fail, check_count);
    if (n_fail == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    `CHK(regRdata, e)
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 100 && convBusy !== 1'b0; i++) @(negedge clk);
    if (convBusy !== 1'b0) begin
      n_fail++;
      $display("BAD %0t conversion hung", $time);
      conclude();
    end
  endtask
  task automatic t_reset();
    @(negedge clk);
    `CHK(muxSel, 8'h00)
    `CHK(converterPower, 1'b0)
    rdc(`AMC_OFS_PAIR, 8'h00);
    rdc(`AMC_OFS_CTRL, 8'h00);
    rdc(`AMC_OFS_CHAN, 8'h00);
    rdc(`AMC_OFS_REF, 8'h00);
    rdc(`AMC_OFS_WIN_HI, 8'hff);
    rdc(`AMC_OFS_WIN_LO, 8'h00);
    rdc(`AMC_OFS_RES_LO, 8'h00);
    rdc(8'h10, 8'h00);
  endtask
  task automatic t_power();
    wr(`AMC_OFS_CTRL, 8'h51);
    @(negedge clk);
    `CHK({converterPower, trackHoldPower, gainAmpPower}, 3'h7)
    `CHK(gainSel, 3'h5)
    rdc(`AMC_OFS_CTRL, 8'h51);
    wr(`AMC_OFS_PAIR, 8'hff);
    rdc(`AMC_OFS_PAIR, 8'h0f);
    wr(`AMC_OFS_CTRL, 8'h03);
    @(negedge clk);
    `CHK(convBusy, 1'b0)
    wr(`AMC_OFS_CTRL, 8'h00);
    @(negedge clk);
    `CHK({converterPower, trackHoldPower, gainAmpPower}, 3'h0)
  endtask
  task automatic t_select();
    for (int p = 0; p < 16; p++) begin
      for (int c = 0; c < 16; c++) begin
        wr(`AMC_OFS_PAIR, 8'(p));
        wr(`AMC_OFS_CHAN, 8'(c));
        @(posedge clk);
        @(negedge clk);
        expSel.tempSel = 1'b0;
        expSel.diff = p[c[2:1]];
        expSel.posCh = expSel.diff ? {c[2:1], 1'b0} : c[2:0];
        expSel.negCh = expSel.diff ? {c[2:1], 1'b1} : 3'h0;
        if (c[3]) `CHK(muxSel.tempSel, 1'b1)
        else `CHK(muxSel, expSel)
      end
    end
  endtask
  task automatic conv(input logic [7:0] p, input logic [7:0] c, input logic [7:0] hi,
      input logic [7:0] lo, input logic [7:0] st);
    wr(`AMC_OFS_PAIR, p);
    wr(`AMC_OFS_CHAN, c);
    wr(`AMC_OFS_CTRL, 8'h03);
    @(negedge clk);
    `CHK({convBusy, trackOn}, 2'h3)
    wait_idle();
    rdc(`AMC_OFS_RES_HI, hi);
    rdc(`AMC_OFS_RES_LO, lo);
    rdc(`AMC_OFS_CTRL, st);
    wr(`AMC_OFS_CTRL, 8'h0d);
    rdc(`AMC_OFS_CTRL, 8'h01);
  endtask
  task automatic t_abort(input logic [7:0] a);
    wr(`AMC_OFS_CTRL, 8'h03);
    repeat (5) @(posedge clk);
    wr(a, 8'h00);
    @(negedge clk);
    `CHK({convBusy, dacCode}, 11'h000)
    rdc(`AMC_OFS_CTRL, {7'h00, a == `AMC_OFS_REF});
    wr(`AMC_OFS_REF, 8'h01);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_power();
    t_select();
    wr(`AMC_OFS_REF, 8'h01);
    @(negedge clk);
    `CHK(biasOn, 1'b1)
    conv(8'h00, 8'h02, 8'h01, 8'h5d, 8'h0d);
    conv(8'h02, 8'h03, 8'hff, 8'ha5, 8'h0d);
    wr(`AMC_OFS_WIN_HI, 8'h80);
    rdc(`AMC_OFS_WIN_HI, 8'h80);
    conv(8'h00, 8'h08, 8'h02, 8'hc9, 8'h05);
    t_abort(`AMC_OFS_CTRL);
    t_abort(`AMC_OFS_REF);
    wr(`AMC_OFS_PAIR, 8'h05);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`AMC_OFS_PAIR, 8'h00);
    rdc(`AMC_OFS_WIN_HI, 8'hff);
    conclude();
  end
endmodule
